/* conv_engine.sv */
/*
  conversion engine on sys_clk: takes a start event from the link domain by
  toggle, runs one conversion at a time, hands result and busy level back.
  assumes the converter value arrives as a plain same-clock input.
*/
`include "sensor_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module conv_engine #(
  parameter int unsigned CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start_tgl,
  input wire logic start_is_temp,
  input wire logic [15:0] pressure_sample,
  input wire logic [15:0] temperature_sample,
  output logic busy,
  output logic [15:0] result
);
  logic s1_q, s2_q, s3_q;
  logic busy_q, busy_d;
  logic [31:0] cnt_q, cnt_d;
  logic [15:0] res_q, res_d;
  logic start_ev;

  assign start_ev = s2_q ^ s3_q;

  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    res_d = res_q;
    if (start_ev && !busy_q) begin
      // one shared converter, so a start arriving while busy is dropped
      busy_d = 1'b1;
      cnt_d = CONV_CYCLES - 1;
    end else if (busy_q) begin
      if (cnt_q == 32'h0) begin
        busy_d = 1'b0;
        res_d = start_is_temp ? temperature_sample : pressure_sample;
      end else begin
        cnt_d = cnt_q - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= 32'h0;
      res_q <= 16'h0;
    end else begin
      s1_q <= start_tgl;
      s2_q <= s1_q;
      s3_q <= s2_q;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
    end
  end

  assign busy = busy_q;
  assign result = res_q;
endmodule
`default_nettype wire

/* ctl_model.sv */
/*
  controller model: makes the serial clock in bursts only, drives data in.
  assumes the port's selection codes and reset pattern from the header.
*/
`include "sensor_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module ctl_model (
  output logic serial_clk,
  output logic data_in,
  input wire logic data_out
);
  initial begin
    serial_clk = 1'b0;
    data_in = 1'b0;
  end
  // clock stands low outside bursts; input changes only while the clock is low
  task automatic pulse(input logic b, output logic q);
    data_in = b;
    #6 serial_clk = 1'b1;
    #6 serial_clk = 1'b0;
    q = data_out;
  endtask
  task automatic frame(input logic [3:0] sel, output logic q);
    logic [9:0] v;
    v = {3'b111, sel, 3'b000};
    for (int i = 9; i >= 0; i--) pulse(v[i], q);
  endtask
  // output may toggle here, so it is not looked at
  task automatic reset_seq();
    logic [20:0] v;
    logic q;
    v = `RESET_PATTERN;
    for (int i = 20; i >= 0; i--) pulse(v[i], q);
    data_in = ~data_in;
  endtask
  task automatic read_word(input int pause_at, output logic [15:0] w);
    logic q;
    for (int i = 0; i < 17; i++) begin
      if (i == pause_at) #700;
      pulse(1'b0, q);
      if (i < 16) w[15-i] = q;
    end
    data_in = 1'b1;
  endtask
  // full readout always follows, so no conversion result is left behind
  task automatic conv(input logic [3:0] sel, input int pause_at, output logic ack, output logic ok,
                      output logic [15:0] w);
    logic q;
    reset_seq();
    frame(sel, ack);
    pulse(1'b0, q);
    pulse(1'b0, q);
    for (int i = 0; i < 400 && data_out !== 1'b0; i++) #100;
    ok = (data_out === 1'b0);
    #300;
    read_word(pause_at, w);
  endtask
endmodule
`default_nettype wire

/* port_props.sv */
/*
  link-side checker of the sensor serial port.
  assumes binding to sensor_serial_port; frames start from idle.
*/
`include "sensor_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module port_props #(
  parameter logic [3:0] SEL_PRESSURE = `SEL_PRESSURE,
  parameter logic [3:0] SEL_TEMPERATURE = `SEL_TEMPERATURE,
  parameter logic [3:0] SEL_CAL_A = `SEL_CAL_A,
  parameter logic [3:0] SEL_CAL_B = `SEL_CAL_B,
  parameter logic [3:0] SEL_CAL_C = `SEL_CAL_C,
  parameter logic [3:0] SEL_CAL_D = `SEL_CAL_D,
  parameter logic [20:0] RESET_PATTERN = `RESET_PATTERN
) (
  input wire logic serial_clk,
  input wire logic rst_n,
  input wire logic data_in,
  input wire logic data_out,
  input wire logic [15:0] calibration_word_a,
  input wire logic [15:0] calibration_word_b,
  input wire logic [15:0] calibration_word_c,
  input wire logic [15:0] calibration_word_d
);
  // ****************
  // bit history
  // ****************
  logic [20:0] hist_q;
  logic [20:0] hist_d;
  always_comb hist_d = {hist_q[19:0], data_in};
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) hist_q <= 21'h0;
    else hist_q <= hist_d;
  end
  function automatic logic [9:0] frm(input logic [3:0] s);
    return {3'b111, s, 3'b000};
  endfunction
  default clocking @(posedge serial_clk); endclocking
  default disable iff (!rst_n);
  // sampled level is the one launched at the previous rise
  AST_ACK_PRESSURE: assert property (hist_q[9:0] == frm(SEL_PRESSURE) |-> data_out [*2] ##1 !data_out)
    else $error("pressure ack or done status wrong");
  AST_ACK_TEMPERATURE: assert property (hist_q[9:0] == frm(SEL_TEMPERATURE) |-> data_out ##1 data_out)
    else $error("temperature ack wrong");
  AST_CAL_A: assert property (hist_q[9:0] == frm(SEL_CAL_A) |=> data_out == calibration_word_a[15])
    else $error("word a first bit wrong");
  AST_CAL_B: assert property (hist_q[9:0] == frm(SEL_CAL_B) |=> data_out == calibration_word_b[15])
    else $error("word b first bit wrong");
  AST_CAL_C: assert property (hist_q[9:0] == frm(SEL_CAL_C) |=> data_out == calibration_word_c[15])
    else $error("word c first bit wrong");
  AST_CAL_D: assert property (hist_q[9:0] == frm(SEL_CAL_D) |=> data_out == calibration_word_d[15])
    else $error("word d first bit wrong");
  AST_CAL_A_TAIL: assert property (hist_q[9:0] == frm(SEL_CAL_A) |-> ##16 data_out == calibration_word_a[0] ##1 !data_out)
    else $error("word a tail wrong");
  AST_RESET_IDLE: assert property (hist_q == RESET_PATTERN |-> ##1 !data_out)
    else $error("not idle after reset pattern");
  CV_PRESSURE: cover property (hist_q[9:0] == frm(SEL_PRESSURE));
  CV_CAL_A: cover property (hist_q[9:0] == frm(SEL_CAL_A));
  CV_RESET: cover property (hist_q == RESET_PATTERN);
endmodule
bind sensor_serial_port port_props #(.SEL_PRESSURE(SEL_PRESSURE), .SEL_TEMPERATURE(SEL_TEMPERATURE),
  .SEL_CAL_A(SEL_CAL_A), .SEL_CAL_B(SEL_CAL_B), .SEL_CAL_C(SEL_CAL_C), .SEL_CAL_D(SEL_CAL_D),
  .RESET_PATTERN(RESET_PATTERN)) u_props (.serial_clk(serial_clk), .rst_n(rst_n), .data_in(data_in),
  .data_out(data_out), .calibration_word_a(calibration_word_a), .calibration_word_b(calibration_word_b),
  .calibration_word_c(calibration_word_c), .calibration_word_d(calibration_word_d));
`default_nettype wire

/* pressure_sensor_serial_port_bench.sv */
/*
  bench of the sensor serial port with a controller model on the link.
  assumes sys_clk at 10 MHz and the link clock of the model at 12 ns.
*/
`include "sensor_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pressure_sensor_serial_port_bench;
  // words c and d get distinct codes, the defaults collide
  localparam logic [3:0] SEL_C = 4'h3;
  localparam logic [3:0] SEL_D = 4'hc;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic serial_clk;
  logic data_in;
  logic data_out;
  logic [15:0] p_s = 16'hb26e;
  logic [15:0] t_s = 16'h6d19;
  logic [15:0] cw [4] = '{16'h9a3c, 16'h5e81, 16'hc4f7, 16'h13d6};
  logic [3:0] sels [4] = '{`SEL_CAL_A, `SEL_CAL_B, SEL_C, SEL_D};
  int bad_count = 0;
  int n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  sensor_serial_port #(.CONV_CYCLES(50), .SEL_CAL_C(SEL_C), .SEL_CAL_D(SEL_D)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .serial_clk(serial_clk), .data_in(data_in), .data_out(data_out), .pressure_sample(p_s),
    .temperature_sample(t_s), .calibration_word_a(cw[0]), .calibration_word_b(cw[1]),
    .calibration_word_c(cw[2]), .calibration_word_d(cw[3]));
  ctl_model u_ctl (.serial_clk(serial_clk), .data_in(data_in), .data_out(data_out));
  task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_bit(input string name, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic test_cal();
    logic q;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      u_ctl.frame(sels[i], q);
      u_ctl.read_word(-1, w);
      check_word("cal word", cw[i], w);
    end
    check_bit("idle status", 1'b0, data_out);
    $display("test_cal done");
  endtask
  task automatic test_pressure();
    logic a;
    logic ok;
    logic [15:0] w;
    u_ctl.conv(`SEL_PRESSURE, -1, a, ok, w);
    check_bit("pressure ack", 1'b1, a);
    check_bit("pressure done", 1'b1, ok);
    check_word("pressure result", p_s, w);
    $display("test_pressure done");
  endtask
  task automatic test_temperature_pause();
    logic a;
    logic ok;
    logic [15:0] w;
    u_ctl.conv(`SEL_TEMPERATURE, 7, a, ok, w);
    check_bit("temperature ack", 1'b1, a);
    check_bit("temperature done", 1'b1, ok);
    check_word("temperature result", t_s, w);
    $display("test_temperature_pause done");
  endtask
  task automatic test_reset_midframe();
    logic q;
    logic [15:0] w;
    for (int i = 0; i < 5; i++) u_ctl.pulse(1'b1, q);
    u_ctl.reset_seq();
    u_ctl.frame(sels[1], q);
    u_ctl.read_word(-1, w);
    check_word("word after reset", cw[1], w);
    $display("test_reset_midframe done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    #13;
    test_cal();
    test_pressure();
    @(negedge sys_clk);
    t_s = 16'h6d19;
    #29;
    test_temperature_pause();
    test_reset_midframe();
    complete_run();
  end
  // the tests need some 16 us; far beyond that means a hang
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire

/* sensor_port_consts.svh */
/*
  constants of the sensor serial port: framing groups, selection codes,
  reset pattern, conversion timing.
  assumes inclusion by the package and the design files by bare name.
*/
//
// Behaviour
// - device captures input bits and launches output bits on serial clock rising edge
// - each instruction opens with three high bits, taken as frame start
// - three low bits follow selection; device then starts the operation
// - device decodes four-bit selection: pressure, temperature or calibration read
// - seven instructions: pressure, temperature, four calibration words, reset
// - conversion start acknowledged by output going low to high
// - conversion end shown by output going high to low
// - seventeen clocks after completion shift out the 16-bit result
// - readout may pause its clock; position is kept
// - a 21-bit reset pattern returns the port to idle from any state
// - four 16-bit calibration words, each read by its own instruction; with the default codes, words c and d decode as temperature and pressure
// - output carries result or calibration data, status between transfers
// - one shared converter makes both 16-bit results, one at a time
`ifndef SENSOR_PORT_CONSTS_SVH
`define SENSOR_PORT_CONSTS_SVH

`define START_BITS 3
`define STOP_BITS 3
`define SEL_BITS 4
`define WORD_BITS 16
`define READ_CLOCKS 17
`define ACK_CLOCKS 2
`define RESET_BITS 21
`define SEL_PRESSURE 4'ha
`define SEL_TEMPERATURE 4'h9
`define SEL_CAL_A 4'h5
`define SEL_CAL_B 4'h6
`define SEL_CAL_C 4'h9
`define SEL_CAL_D 4'ha
`define RESET_PATTERN 21'h15555
`define CONV_TIME_MS 35
`define SYS_CLK_HZ 10000000
`define CONV_CYCLES ((`CONV_TIME_MS * `SYS_CLK_HZ) / 1000)

`endif

/* sensor_port_pkg.sv */
/*
  types of the sensor serial port.
  assumes the constants header beside it.
*/
`include "sensor_port_consts.svh"
package sensor_port_pkg;
  typedef enum logic [3:0] {
    cmd_none = 4'h0,
    cmd_pressure = 4'h1,
    cmd_temperature = 4'h2,
    cmd_cal_a = 4'h3,
    cmd_cal_b = 4'h4,
    cmd_cal_c = 4'h5,
    cmd_cal_d = 4'h6
  } cmd_t;
endpackage

/* sensor_serial_port.sv */
/*
  three-wire serial port of the sensor: frame decode on the serial clock,
  calibration and result shift-out, conversion status on data out.
  assumes serial clock stops low between groups; conversion on sys_clk.
*/
`include "sensor_port_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sensor_serial_port #(
  parameter int unsigned CONV_CYCLES = `CONV_CYCLES,
  parameter logic [3:0] SEL_PRESSURE = `SEL_PRESSURE,
  parameter logic [3:0] SEL_TEMPERATURE = `SEL_TEMPERATURE,
  parameter logic [3:0] SEL_CAL_A = `SEL_CAL_A,
  parameter logic [3:0] SEL_CAL_B = `SEL_CAL_B,
  parameter logic [3:0] SEL_CAL_C = `SEL_CAL_C,
  parameter logic [3:0] SEL_CAL_D = `SEL_CAL_D,
  parameter logic [20:0] RESET_PATTERN = `RESET_PATTERN
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic data_in,
  output logic data_out,
  input wire logic [15:0] pressure_sample,
  input wire logic [15:0] temperature_sample,
  input wire logic [15:0] calibration_word_a,
  input wire logic [15:0] calibration_word_b,
  input wire logic [15:0] calibration_word_c,
  input wire logic [15:0] calibration_word_d
);
  // ************************************
  // link-side state
  // ************************************
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_sel = 3'b001,
    st_stop = 3'b011,
    st_ack = 3'b010,
    st_wait = 3'b110,
    st_read = 3'b111
  } st_t;

  st_t st_q, st_d;
  logic [20:0] hist_q, hist_d;
  logic [1:0] ones_q, ones_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] sel_q, sel_d;
  sensor_port_pkg::cmd_t cmd_q, cmd_d;
  logic [16:0] sh_q, sh_d;
  logic dout_q, dout_d;
  logic tgl_q, tgl_d;
  logic temp_q, temp_d;
  logic busy_l1_q, busy_l2_q;
  logic [20:0] hist_next;
  logic conv_busy;
  logic [15:0] conv_result;

  assign hist_next = {hist_q[19:0], data_in};

  always_comb begin
    st_d = st_q;
    hist_d = hist_next;
    ones_d = ones_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    cmd_d = cmd_q;
    sh_d = sh_q;
    dout_d = dout_q;
    tgl_d = tgl_q;
    temp_d = temp_q;
    if (hist_next == RESET_PATTERN) begin
      st_d = st_idle;
      ones_d = 2'h0;
      dout_d = 1'b0;
      cmd_d = sensor_port_pkg::cmd_none;
    end else begin
      case (st_q)
        st_idle: begin
          // three consecutive ones open a frame
          if (data_in) begin
            if (ones_q == 2'(`START_BITS - 1)) begin
              st_d = st_sel;
              cnt_d = 5'h0;
              ones_d = 2'h0;
            end else begin
              ones_d = ones_q + 2'h1;
            end
          end else begin
            ones_d = 2'h0;
          end
        end
        st_sel: begin
          sel_d = {sel_q[2:0], data_in};
          if (cnt_q == 5'(`SEL_BITS - 1)) begin
            st_d = st_stop;
            cnt_d = 5'h0;
          end else begin
            cnt_d = cnt_q + 5'h1;
          end
        end
        st_stop: begin
          if (data_in) begin
            st_d = st_idle; // broken stop group drops the frame
          end else if (cnt_q == 5'(`STOP_BITS - 1)) begin
            cnt_d = 5'h0;
            // pressure and temperature share codes with words d and c;
            // the bit checked before the selection field is always the last start one, so pressure and temperature win
            if (hist_q[6] && sel_q == SEL_PRESSURE) begin
              cmd_d = sensor_port_pkg::cmd_pressure;
            end else if (hist_q[6] && sel_q == SEL_TEMPERATURE) begin
              cmd_d = sensor_port_pkg::cmd_temperature;
            end else if (sel_q == SEL_CAL_A) begin
              cmd_d = sensor_port_pkg::cmd_cal_a;
            end else if (sel_q == SEL_CAL_B) begin
              cmd_d = sensor_port_pkg::cmd_cal_b;
            end else if (sel_q == SEL_CAL_C) begin
              cmd_d = sensor_port_pkg::cmd_cal_c;
            end else if (sel_q == SEL_CAL_D) begin
              cmd_d = sensor_port_pkg::cmd_cal_d;
            end else begin
              cmd_d = sensor_port_pkg::cmd_none;
            end
            if (hist_q[6] && (sel_q == SEL_PRESSURE || sel_q == SEL_TEMPERATURE)) begin
              st_d = st_ack;
              dout_d = 1'b1;
              tgl_d = ~tgl_q;
              temp_d = (sel_q == SEL_TEMPERATURE);
            end else begin
              st_d = st_read;
              case (sel_q)
                SEL_CAL_A: sh_d = {calibration_word_a, 1'b0};
                SEL_CAL_B: sh_d = {calibration_word_b, 1'b0};
                SEL_CAL_C: sh_d = {calibration_word_c, 1'b0};
                SEL_CAL_D: sh_d = {calibration_word_d, 1'b0};
                default: sh_d = 17'h0;
              endcase
            end
          end else begin
            cnt_d = cnt_q + 5'h1;
          end
        end
        st_ack: begin
          // two more clocks after the acknowledge, output stays high
          if (cnt_q == 5'(`ACK_CLOCKS - 1)) begin
            st_d = st_wait;
            cnt_d = 5'h0;
          end else begin
            cnt_d = cnt_q + 5'h1;
          end
        end
        st_wait: begin
          // a clock ends the wait whenever busy_l2_q is low, which is conv_busy as seen two serial clocks earlier
          // the waking edge already launches the top bit, so 17 edges cover 16 bits and a trailing zero
          if (!busy_l2_q) begin
            st_d = st_read;
            dout_d = conv_result[15];
            sh_d = {conv_result[14:0], 2'b00};
            cnt_d = 5'h1;
          end
        end
        st_read: begin
          dout_d = sh_q[16];
          sh_d = {sh_q[15:0], 1'b0};
          if (cnt_q == 5'(`READ_CLOCKS - 1)) begin
            st_d = st_idle;
            cnt_d = 5'h0;
          end else begin
            cnt_d = cnt_q + 5'h1;
          end
        end
        default: st_d = st_idle;
      endcase
    end
  end

  // ************************************
  // link registers, serial clock rising edge
  // ************************************
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= st_idle;
      hist_q <= 21'h0;
      ones_q <= 2'h0;
      cnt_q <= 5'h0;
      sel_q <= 4'h0;
      cmd_q <= sensor_port_pkg::cmd_none;
      sh_q <= 17'h0;
      dout_q <= 1'b0;
      tgl_q <= 1'b0;
      temp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hist_q <= hist_d;
      ones_q <= ones_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      cmd_q <= cmd_d;
      sh_q <= sh_d;
      dout_q <= dout_d;
      tgl_q <= tgl_d;
      temp_q <= temp_d;
    end
  end

  // ************************************
  // completion crossing and status output
  // ************************************
  // serial clock is held low during conversion, so completion must drive
  // data out combinationally from a synchronised sys_clk level
  logic busy_s1_q, busy_s2_q, wait_s1_q, wait_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= conv_busy;
      busy_s2_q <= busy_s1_q;
      wait_s1_q <= (st_q == st_ack) || (st_q == st_wait);
      wait_s2_q <= wait_s1_q;
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_l1_q <= 1'b0;
      busy_l2_q <= 1'b0;
    end else begin
      busy_l1_q <= conv_busy;
      busy_l2_q <= busy_l1_q;
    end
  end

  // set once the conversion is seen busy in ack or wait state, cleared outside them
  logic pending_q, pending_d;
  always_comb begin
    pending_d = pending_q;
    if (!wait_s2_q) begin
      pending_d = 1'b0;
    end else if (busy_s2_q) begin
      pending_d = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
    end
  end

  // in wait state output follows conversion status
  assign data_out = (st_q == st_wait) ? !(pending_q && !busy_s2_q) : dout_q;

  conv_engine #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start_tgl(tgl_q),
    .start_is_temp(temp_q),
    .pressure_sample(pressure_sample),
    .temperature_sample(temperature_sample),
    .busy(conv_busy),
    .result(conv_result)
  );
endmodule
`default_nettype wire
